// File: pkg/rtc_pkg.sv
// Package: register map, field layouts, reset values and timing constants of the RTC
package rtc_pkg;
  // Crystal and system clock rates
  localparam int unsigned XTAL_HZ         = 32768;
  localparam int unsigned SYS_CLK_HZ      = 50_000_000;
  // Register offsets, byte addresses
  localparam logic [7:0] OFS_TIME         = 8'h00;
  localparam logic [7:0] OFS_CTRL         = 8'h04;
  localparam logic [7:0] OFS_STATUS       = 8'h08;
  localparam logic [7:0] OFS_ALARM        = 8'h0C;
  localparam logic [7:0] OFS_SWATCH       = 8'h10;
  localparam logic [7:0] OFS_WAKE_EN      = 8'h14;
  // Time word layout: day[24:17] hour[16:12] min[11:6] sec[5:0]
  localparam int unsigned SEC_LSB         = 0;
  localparam int unsigned MIN_LSB         = 6;
  localparam int unsigned HOUR_LSB        = 12;
  localparam int unsigned DAY_LSB         = 17;
  localparam int unsigned TIME_W          = 25;
  // Control and status bit positions
  localparam int unsigned EV_SEC          = 0;
  localparam int unsigned EV_MIN          = 1;
  localparam int unsigned EV_DAY          = 2;
  localparam int unsigned EV_ALARM_TOD    = 3;
  localparam int unsigned EV_ALARM_DAY    = 4;
  localparam int unsigned EV_SWATCH       = 5;
  localparam int unsigned NUM_EV          = 6;
  // Wrap limits
  localparam logic [5:0] SEC_MAX          = 6'h3B;
  localparam logic [5:0] MIN_MAX          = 6'h3B;
  localparam logic [4:0] HOUR_MAX         = 5'h17;
  // Reset values
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic [15:0] SWATCH_RST      = 16'h0000;

  typedef struct packed {
    logic [7:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } time_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
endpackage : rtc_pkg

// File: src/rtc_time_alarm_stopwatch.sv
// RTC core: crystal prescaler, time counters, alarms, stopwatch, event flags, wake-up
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RULE1) The crystal clock is divided by a prescaler into a one-hertz tick that advances time.
// (RULE2) Time is held in cascaded 6-bit second, 6-bit minute, 5-bit hour and 8-bit day counters.
// (RULE3) Second, minute and day ticks each raise their own separately enabled interrupt.
// (RULE4) While an alarm is enabled, a match of running time with the alarm value raises an interrupt.
// (RULE5) The time-of-day alarm compares hour, minute and second only, so it fires daily.
// (RULE6) The day alarm compares day count plus time of day, so it fires once on that day.
// (RULE7) The stopwatch loads a software value and counts it down once per minute.
// (RULE8) An enabled stopwatch that underflows raises a stopwatch interrupt.
// (RULE9) Any pending enabled interrupt of the block can wake the processor.
// (RULE10) Timekeeping runs from the crystal alone, independent of the processor clock; here all counters run on clk, with xtal_in only sampled.
// (RULE11) Wake-up is given only when the block's wake-up enable bit is set.
// (RULE12) Seconds and minutes wrap 59 to 0 with carry; hours wrap 23 to 0 and bump the day.
// (RULE13) Each cause sets a sticky flag that stays until software writes one to it; here a cause sets its flag only while its interrupt enable is set.
module rtc_time_alarm_stopwatch #(
  parameter int unsigned PRESCALE = rtc_pkg::XTAL_HZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Crystal clock pin, sampled into clk domain
  input  wire logic        xtal_in,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Interrupt and wake-up
  output logic             irq,
  output logic             wake
);
  localparam int unsigned PW = $clog2(PRESCALE);

  // Crystal synchroniser and edge detect
  logic xs1_r, xs2_r, xs3_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end else begin
      xs1_r <= xtal_in;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end
  wire xtal_rise = xs2_r & ~xs3_r;

  // Prescaler: one-hertz enable pulse
  logic [PW-1:0] pre_r;
  wire           pre_last = (pre_r == PW'(PRESCALE - 1));
  wire           tick_sec = xtal_rise & pre_last;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pre_r <= '0;
    else if (xtal_rise) pre_r <= pre_last ? '0 : pre_r + 1'b1; // RULE1 RULE10
  end

  // Register decode
  wire sel_time   = (addr == rtc_pkg::OFS_TIME);
  wire sel_ctrl   = (addr == rtc_pkg::OFS_CTRL);
  wire sel_status = (addr == rtc_pkg::OFS_STATUS);
  wire sel_alarm  = (addr == rtc_pkg::OFS_ALARM);
  wire sel_swatch = (addr == rtc_pkg::OFS_SWATCH);
  wire sel_wake   = (addr == rtc_pkg::OFS_WAKE_EN);

  // Time counters
  rtc_pkg::time_t tm_r;
  wire sec_wrap  = (tm_r.sec == rtc_pkg::SEC_MAX);
  wire min_wrap  = (tm_r.min == rtc_pkg::MIN_MAX);
  wire hour_wrap = (tm_r.hour == rtc_pkg::HOUR_MAX);
  wire tick_min  = tick_sec & sec_wrap;
  wire tick_day  = tick_min & min_wrap & hour_wrap;
  rtc_pkg::time_t tm_nxt;
  always_comb begin
    tm_nxt = tm_r;
    if (wr && sel_time) begin
      tm_nxt = rtc_pkg::time_t'(wdata[rtc_pkg::TIME_W-1:0]);
    end else if (tick_sec) begin
      tm_nxt.sec = sec_wrap ? 6'h00 : tm_r.sec + 6'h01; // RULE2 RULE12
      if (sec_wrap) begin
        tm_nxt.min = min_wrap ? 6'h00 : tm_r.min + 6'h01; // RULE12
        if (min_wrap) begin
          tm_nxt.hour = hour_wrap ? 5'h00 : tm_r.hour + 5'h01; // RULE12
          if (hour_wrap) tm_nxt.day = tm_r.day + 8'h01; // RULE12
        end
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) tm_r <= '0;
    else tm_r <= tm_nxt;
  end

  // Control: bits [5:0] interrupt enables, bit 8 stopwatch run
  logic [rtc_pkg::NUM_EV-1:0] ien_r;
  logic                       sw_run_r;
  logic                       wake_en_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ien_r     <= '0;
      sw_run_r  <= 1'b0;
      wake_en_r <= 1'b0;
    end else begin
      if (wr && sel_ctrl) begin
        ien_r    <= wdata[rtc_pkg::NUM_EV-1:0];
        sw_run_r <= wdata[8];
      end
      if (wr && sel_wake) wake_en_r <= wdata[0];
    end
  end

  // Alarm value; matches are checked one cycle after a second tick
  rtc_pkg::time_t alm_r;
  logic           chk_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alm_r <= '0;
      chk_r <= 1'b0;
    end else begin
      if (wr && sel_alarm) alm_r <= rtc_pkg::time_t'(wdata[rtc_pkg::TIME_W-1:0]);
      chk_r <= tick_sec;
    end
  end
  wire tod_eq      = (tm_r.hour == alm_r.hour) & (tm_r.min == alm_r.min)
                   & (tm_r.sec == alm_r.sec); // RULE5
  wire hit_tod     = chk_r & tod_eq & ien_r[rtc_pkg::EV_ALARM_TOD]; // RULE4
  wire hit_day     = chk_r & tod_eq & (tm_r.day == alm_r.day)
                   & ien_r[rtc_pkg::EV_ALARM_DAY]; // RULE4 RULE6

  // Stopwatch, decrements on each minute tick
  logic [15:0] sw_r;
  wire         sw_zero  = (sw_r == 16'h0000);
  wire         hit_sw   = sw_run_r & tick_min & sw_zero; // RULE8
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) sw_r <= rtc_pkg::SWATCH_RST;
    else if (wr && sel_swatch) sw_r <= wdata[15:0]; // RULE7
    else if (sw_run_r && tick_min) sw_r <= sw_r - 16'h0001; // RULE7
  end

  // Sticky status flags, set wins over write-one-to-clear
  logic [rtc_pkg::NUM_EV-1:0] st_r;
  wire  [rtc_pkg::NUM_EV-1:0] ev_set;
  assign ev_set[rtc_pkg::EV_SEC]       = tick_sec & ien_r[rtc_pkg::EV_SEC]; // RULE3
  assign ev_set[rtc_pkg::EV_MIN]       = tick_min & ien_r[rtc_pkg::EV_MIN]; // RULE3
  assign ev_set[rtc_pkg::EV_DAY]       = tick_day & ien_r[rtc_pkg::EV_DAY]; // RULE3
  assign ev_set[rtc_pkg::EV_ALARM_TOD] = hit_tod;
  assign ev_set[rtc_pkg::EV_ALARM_DAY] = hit_day;
  assign ev_set[rtc_pkg::EV_SWATCH]    = hit_sw & ien_r[rtc_pkg::EV_SWATCH];
  wire [rtc_pkg::NUM_EV-1:0] clr = (wr && sel_status) ? wdata[rtc_pkg::NUM_EV-1:0] : '0;
  wire [rtc_pkg::NUM_EV-1:0] st_nxt = (st_r & ~clr) | ev_set; // RULE13
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st_r <= '0;
    else st_r <= st_nxt;
  end

  // Outputs from flops
  wire [31:0] rd_mux =
      sel_time   ? 32'(tm_r) :
      sel_ctrl   ? {23'h0, sw_run_r, 2'b00, ien_r} :
      sel_status ? {26'h0, st_r} :
      sel_alarm  ? 32'(alm_r) :
      sel_swatch ? {16'h0000, sw_r} :
      sel_wake   ? {31'h0, wake_en_r} : rtc_pkg::RST_WORD;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= rtc_pkg::RST_WORD;
      irq   <= 1'b0;
      wake  <= 1'b0;
    end else begin
      rdata <= rd ? rd_mux : rtc_pkg::RST_WORD;
      irq   <= |st_nxt;
      wake  <= (|st_nxt) & wake_en_r; // RULE9 RULE11
    end
  end

  // Assertions
  sequence s_last_sec;
    tick_sec && sec_wrap && !(wr && sel_time);
  endsequence

  property p_sec_wrap;
    @(posedge clk) disable iff (!nrst) s_last_sec |=> (tm_r.sec == 6'h00);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap"); // RULE12

  property p_sec_inc;
    @(posedge clk) disable iff (!nrst)
      (tick_sec && !sec_wrap && !(wr && sel_time)) |=> (tm_r.sec == $past(tm_r.sec) + 6'h01);
  endproperty
  a_sec_inc: assert property (p_sec_inc) else $error("seconds did not advance"); // RULE2

  property p_hold;
    @(posedge clk) disable iff (!nrst) (!tick_sec && !wr) |=> $stable(tm_r);
  endproperty
  a_hold: assert property (p_hold) else $error("time moved without tick"); // RULE1

  property p_hour_wrap;
    @(posedge clk) disable iff (!nrst)
      (tick_day && !(wr && sel_time)) |=> (tm_r.hour == 5'h00 && tm_r.day == $past(tm_r.day) + 8'h01);
  endproperty
  a_hour_wrap: assert property (p_hour_wrap) else $error("day rollover wrong"); // RULE12

  property p_sticky;
    @(posedge clk) disable iff (!nrst)
      (st_r[rtc_pkg::EV_SEC] && !(wr && sel_status)) |=> st_r[rtc_pkg::EV_SEC];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear"); // RULE13

  property p_sec_irq;
    @(posedge clk) disable iff (!nrst) ev_set[rtc_pkg::EV_SEC] |=> (st_r[rtc_pkg::EV_SEC] && irq);
  endproperty
  a_sec_irq: assert property (p_sec_irq) else $error("second event missing"); // RULE3

  // Match is built from the fields, day left out, independent of hit_tod
  sequence s_tod_match;
    chk_r && ien_r[rtc_pkg::EV_ALARM_TOD] && (tm_r.hour == alm_r.hour)
      && (tm_r.min == alm_r.min) && (tm_r.sec == alm_r.sec);
  endsequence

  property p_alarm_tod;
    @(posedge clk) disable iff (!nrst) s_tod_match |=> st_r[rtc_pkg::EV_ALARM_TOD];
  endproperty
  a_alarm_tod: assert property (p_alarm_tod) else $error("alarm not flagged"); // RULE4 RULE5

  property p_sw_dec;
    @(posedge clk) disable iff (!nrst)
      (sw_run_r && tick_min && !(wr && sel_swatch)) |=> (sw_r == $past(sw_r) - 16'h0001);
  endproperty
  a_sw_dec: assert property (p_sw_dec) else $error("stopwatch did not decrement"); // RULE7

  // Wake uses the enable as it stood one edge earlier, so a disabling write lags a cycle
  property p_wake;
    @(posedge clk) disable iff (!nrst) wake |-> ($past(wake_en_r) && irq);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without enable"); // RULE11

  property p_wake_on;
    @(posedge clk) disable iff (!nrst) ((|ev_set) && wake_en_r) |=> wake;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("enabled event gave no wake"); // RULE9 RULE11

  property p_alarm_day;
    @(posedge clk) disable iff (!nrst)
      (chk_r && ien_r[rtc_pkg::EV_ALARM_DAY] && (tm_r == alm_r))
        |=> st_r[rtc_pkg::EV_ALARM_DAY];
  endproperty
  a_alarm_day: assert property (p_alarm_day) else $error("day alarm not flagged"); // RULE6

  property p_sw_under;
    @(posedge clk) disable iff (!nrst)
      (sw_run_r && tick_min && (sw_r == 16'h0000) && ien_r[rtc_pkg::EV_SWATCH])
        |=> (st_r[rtc_pkg::EV_SWATCH] && irq);
  endproperty
  a_sw_under: assert property (p_sw_under) else $error("underflow not flagged"); // RULE8

  property p_sw_idle;
    @(posedge clk) disable iff (!nrst) (!sw_run_r && !(wr && sel_swatch)) |=> $stable(sw_r);
  endproperty
  a_sw_idle: assert property (p_sw_idle) else $error("stopwatch moved while halted"); // RULE7

  property p_min_inc;
    @(posedge clk) disable iff (!nrst)
      (tick_sec && sec_wrap && !min_wrap && !(wr && sel_time))
        |=> (tm_r.min == $past(tm_r.min) + 6'h01);
  endproperty
  a_min_inc: assert property (p_min_inc) else $error("minute carry lost"); // RULE12

  property p_min_irq;
    @(posedge clk) disable iff (!nrst)
      (tick_sec && sec_wrap && ien_r[rtc_pkg::EV_MIN]) |=> st_r[rtc_pkg::EV_MIN];
  endproperty
  a_min_irq: assert property (p_min_irq) else $error("minute event missing"); // RULE3

  property p_day_irq;
    @(posedge clk) disable iff (!nrst)
      (tick_sec && sec_wrap && min_wrap && hour_wrap && ien_r[rtc_pkg::EV_DAY])
        |=> st_r[rtc_pkg::EV_DAY];
  endproperty
  a_day_irq: assert property (p_day_irq) else $error("day event missing"); // RULE3

  property p_clear;
    @(posedge clk) disable iff (!nrst)
      (wr && sel_status && wdata[rtc_pkg::EV_SEC] && !ev_set[rtc_pkg::EV_SEC])
        |=> !st_r[rtc_pkg::EV_SEC];
  endproperty
  a_clear: assert property (p_clear) else $error("flag survived its clear"); // RULE13

  // Checker only: crystal rises seen since the last second tick
  localparam logic [PW:0] RISE_TOP = (PW+1)'(PRESCALE - 1);
  logic [PW:0] rise_cnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rise_cnt_r <= '0;
    else if (tick_sec) rise_cnt_r <= '0;
    else if (xtal_rise) rise_cnt_r <= rise_cnt_r + 1'b1;
  end

  property p_prescale;
    @(posedge clk) disable iff (!nrst) tick_sec |-> (rise_cnt_r == RISE_TOP);
  endproperty
  a_prescale: assert property (p_prescale) else $error("tick off rise count"); // RULE1

  property p_rise_cap;
    @(posedge clk) disable iff (!nrst) (rise_cnt_r <= RISE_TOP);
  endproperty
  a_rise_cap: assert property (p_rise_cap) else $error("second tick missed"); // RULE1 RULE10
endmodule : rtc_time_alarm_stopwatch

`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the RTC core: time, alarms, stopwatch, flags and wake-up
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        xtal_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic        wake;
  int          n_errors = 0;
  int          check_count = 0;
  logic [31:0] v;

  rtc_time_alarm_stopwatch #(.PRESCALE(4)) i_rtc_time_alarm_stopwatch (
    .clk(clk), .nrst(nrst), .xtal_in(xtal_in), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake(wake));

  always #10 clk = ~clk;

  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  function automatic logic [31:0] mk(input logic [7:0] dd, input logic [4:0] h,
                                     input logic [5:0] m, input logic [5:0] s);
    return {7'h00, dd, h, m, s};
  endfunction : mk

  // Whole prescaler periods only, so the divider phase stays aligned
  task automatic sec_tick;
    repeat (4) begin
      @(posedge clk) xtal_in <= 1'b1;
      repeat (4) @(posedge clk);
      xtal_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask : sec_tick

  task automatic t_reset_vals;
    logic [7:0] a;
    for (int i = 0; i < 7; i++) begin
      a = 8'(i * 4);
      rd_reg(a, v);
      chk(v, 32'h0000_0000);
    end
    chk({30'h0, irq, wake}, 32'h0000_0000);
  endtask : t_reset_vals

  task automatic t_wrap;
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0001);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h05, 5'h00, 6'h00, 6'h05));
    sec_tick();
    rd_reg(rtc_pkg::OFS_TIME, v);
    chk(v, mk(8'h05, 5'h00, 6'h00, 6'h06));
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0001);
    chk({31'h0, wake}, 32'h0000_0000);
    wr_reg(rtc_pkg::OFS_WAKE_EN, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({30'h0, irq, wake}, 32'h0000_0003);
    wr_reg(rtc_pkg::OFS_STATUS, 32'h0000_003F);
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0006);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h05, 5'h17, 6'h3B, 6'h3B));
    sec_tick();
    rd_reg(rtc_pkg::OFS_TIME, v);
    chk(v, mk(8'h06, 5'h00, 6'h00, 6'h00));
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0006);
    wr_reg(rtc_pkg::OFS_STATUS, 32'h0000_0002);
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0004);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'hFF, 5'h17, 6'h3B, 6'h3B));
    sec_tick();
    rd_reg(rtc_pkg::OFS_TIME, v);
    chk(v, mk(8'h00, 5'h00, 6'h00, 6'h00));
    wr_reg(rtc_pkg::OFS_STATUS, 32'h0000_003F);
    repeat (2) @(posedge clk);
    chk({30'h0, irq, wake}, 32'h0000_0000);
  endtask : t_wrap

  task automatic t_alarm;
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0018);
    wr_reg(rtc_pkg::OFS_ALARM, mk(8'h09, 5'h01, 6'h02, 6'h03));
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h03, 5'h01, 6'h02, 6'h02));
    sec_tick();
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0008);
    wr_reg(rtc_pkg::OFS_STATUS, 32'h0000_003F);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h09, 5'h01, 6'h02, 6'h02));
    sec_tick();
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0018);
    wr_reg(rtc_pkg::OFS_STATUS, 32'h0000_003F);
    // Day alarm alone: a matching time of day must stay silent when disabled
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0010);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h09, 5'h01, 6'h02, 6'h02));
    sec_tick();
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0010);
    wr_reg(rtc_pkg::OFS_STATUS, 32'h0000_003F);
  endtask : t_alarm

  task automatic t_swatch;
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0120);
    wr_reg(rtc_pkg::OFS_SWATCH, 32'h0000_0001);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h00, 5'h00, 6'h00, 6'h3B));
    sec_tick();
    rd_reg(rtc_pkg::OFS_SWATCH, v);
    chk(v, 32'h0000_0000);
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0000);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h00, 5'h00, 6'h01, 6'h3B));
    sec_tick();
    rd_reg(rtc_pkg::OFS_SWATCH, v);
    chk(v, 32'h0000_FFFF);
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0020);
    chk({31'h0, irq}, 32'h0000_0001);
    // Halted stopwatch: no count and no underflow flag across a minute tick
    wr_reg(rtc_pkg::OFS_STATUS, 32'h0000_003F);
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0020);
    wr_reg(rtc_pkg::OFS_SWATCH, 32'h0000_0000);
    wr_reg(rtc_pkg::OFS_TIME, mk(8'h00, 5'h00, 6'h02, 6'h3B));
    sec_tick();
    rd_reg(rtc_pkg::OFS_SWATCH, v);
    chk(v, 32'h0000_0000);
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0000);
  endtask : t_swatch

  // Reset in mid-run: flags, outputs and time cleared, prescaler restarts its count
  task automatic t_reset_mid;
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0001);
    wr_reg(rtc_pkg::OFS_WAKE_EN, 32'h0000_0001);
    sec_tick();
    chk({30'h0, irq, wake}, 32'h0000_0003);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0000);
    chk({30'h0, irq, wake}, 32'h0000_0000);
    wr_reg(rtc_pkg::OFS_CTRL, 32'h0000_0001);
    sec_tick();
    rd_reg(rtc_pkg::OFS_TIME, v);
    chk(v, mk(8'h00, 5'h00, 6'h00, 6'h01));
    rd_reg(rtc_pkg::OFS_STATUS, v);
    chk(v, 32'h0000_0001);
  endtask : t_reset_mid

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset_vals();
    t_wrap();
    t_alarm();
    t_swatch();
    t_reset_mid();
    tally_and_finish();
  end

  // About a dozen ticks of 44 cycles each, plus register traffic, fit well inside this span
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
